// ===== core/mode_config_defs.svh
`ifndef MODE_CONFIG_DEFS_SVH
`define MODE_CONFIG_DEFS_SVH

// register byte addresses on the apb window (one word each)
`define ADDR_PARALLEL_MODE_SELECT     8'h00
`define ADDR_PARALLEL_FLOPPY_MUX      8'h04
`define ADDR_UART1_MODE_SELECT        8'h08
`define ADDR_UART2_MODE_SELECT        8'h0C
`define ADDR_INFRARED_OPTIONS         8'h10
`define ADDR_INFRARED_TURNAROUND_TIME 8'h14
`define ADDR_STATUS                   8'h18

// printed register index of each register inside its logical device
`define IDX_PARALLEL_MODE_SELECT      8'hF0
`define IDX_PARALLEL_FLOPPY_MUX       8'hF1
`define IDX_UART_MODE_SELECT          8'hF0
`define IDX_INFRARED_OPTIONS          8'hF1
`define IDX_INFRARED_TURNAROUND_TIME  8'hF2

// reset values
`define RST_PARALLEL_MODE_SELECT      8'h3C
`define RST_PARALLEL_FLOPPY_MUX       8'h00
`define RST_UART_MODE_SELECT          8'h00
`define RST_INFRARED_OPTIONS          8'h02
`define RST_INFRARED_TURNAROUND_TIME  8'h03

// writable bit masks, reserved bits stay zero
`define MASK_PARALLEL_MODE_SELECT     8'hFF
`define MASK_PARALLEL_FLOPPY_MUX      8'h03
`define MASK_UART1_MODE_SELECT        8'h83
`define MASK_UART2_MODE_SELECT        8'h03
`define MASK_INFRARED_OPTIONS         8'h7F

// field positions
`define BIT_PP_IRQ_TYPE               7
`define BIT_UART_MIDI                 0
`define BIT_UART_HIGH_SPEED           1
`define BIT_UART_SHARE_IRQ            7
`define BIT_IR_RX_POL                 0
`define BIT_IR_TX_POL                 1
`define BIT_IR_HALF_DUPLEX            2
`define BIT_IR_LOCATION               6

// timing: one blanking step is 100 us, clock is 10 MHz
`define STEP_TIME_US                  100
`define CLK_MHZ                       10
`define STEP_CYCLES                   (`STEP_TIME_US * `CLK_MHZ)
`define IRQ_PULSE_CYCLES              4

`endif

// ===== core/mode_config_pkg.sv
package mode_config_pkg;

	// parallel port mode field encodings
	typedef enum logic [2:0] {
		PP_SPP        = 3'b000,
		PP_EPP19      = 3'b001,
		PP_ECP        = 3'b010,
		PP_ECP_EPP19  = 3'b011,
		PP_PRINTER    = 3'b100,
		PP_EPP17      = 3'b101,
		PP_RESERVED   = 3'b110,
		PP_ECP_EPP17  = 3'b111
	} pp_mode_e;

	// infrared mode field encodings
	typedef enum logic [2:0] {
		IR_STANDARD   = 3'b000,
		IR_IRDA       = 3'b001,
		IR_ASK        = 3'b010,
		IR_RESERVED   = 3'b011
	} ir_mode_e;

	// floppy over parallel routing
	typedef enum logic [1:0] {
		FM_NORMAL     = 2'b00,
		FM_SPLIT      = 2'b01,
		FM_BOTH       = 2'b10,
		FM_UNUSED     = 2'b11
	} floppy_mux_e;

	// blanking sequencer states
	typedef enum logic [1:0] {
		BL_IDLE       = 2'b00,
		BL_TRANSMIT   = 2'b01,
		BL_HOLD       = 2'b10
	} blank_state_e;

endpackage

// ===== core/irq_pulse_gen.sv
`include "mode_config_defs.svh"

// turns a rising request edge into a fixed low pulse with high-z release
module irq_pulse_gen
	import mode_config_pkg::*;
(
	input  wire logic pclk,          // system clock
	input  wire logic presetn,       // async reset, active low
	input  wire logic req,           // interrupt source level
	output logic      pulse_active   // high while the low pulse is driven
);

	typedef struct packed {
		logic       req_d;
		logic [2:0] cnt;
	} pulse_s;

	pulse_s st_ff;
	pulse_s nxt_st;

	// count down a fixed pulse width after each rising edge of the source
	always_comb begin
		nxt_st       = st_ff;
		nxt_st.req_d = req;
		if (req && !st_ff.req_d) begin
			nxt_st.cnt = 3'(`IRQ_PULSE_CYCLES);
		end else if (st_ff.cnt != 3'h0) begin
			nxt_st.cnt = st_ff.cnt - 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pulse_active = (st_ff.cnt != 3'h0);

	// pulse lasts the full width; a fresh edge may only stretch it
	pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn) // RL3
		$rose(pulse_active) |-> pulse_active [*4])
		else $error("interrupt pulse too short");

endmodule

// ===== core/ir_blank_timer.sv
`include "mode_config_defs.svh"

// receive blanking for half duplex infrared turnaround
module ir_blank_timer
	import mode_config_pkg::*;
(
	input  wire logic       pclk,         // system clock
	input  wire logic       presetn,      // async reset, active low
	input  wire logic       half_duplex,  // half duplex selected
	input  wire logic       tx_active,    // infrared transmitter busy
	input  wire logic [7:0] timeout,      // turnaround in 100 us steps
	output logic            rx_blank      // receiver blanked
);

	typedef struct packed {
		blank_state_e state;
		logic [9:0]   pre;
		logic [7:0]   steps;
	} blank_s;

	blank_s st_ff;
	blank_s nxt_st;

	localparam logic [9:0] STEP_LAST = 10'(`STEP_CYCLES - 1);

	// RL19 blanking after transmit
	always_comb begin
		nxt_st = st_ff;
		case (st_ff.state)
			BL_IDLE: begin
				if (half_duplex && tx_active) begin
					nxt_st.state = BL_TRANSMIT;
				end
			end
			BL_TRANSMIT: begin
				nxt_st.pre   = 10'h000;
				nxt_st.steps = timeout;
				if (!tx_active) begin
					nxt_st.state = (timeout == 8'h00) ? BL_IDLE : BL_HOLD;
				end
			end
			BL_HOLD: begin
				if (tx_active) begin
					nxt_st.state = BL_TRANSMIT;
				end else if (st_ff.pre == STEP_LAST) begin
					nxt_st.pre   = 10'h000;
					nxt_st.steps = st_ff.steps - 8'h01;
					if (st_ff.steps == 8'h01) begin
						nxt_st.state = BL_IDLE;
					end
				end else begin
					nxt_st.pre = st_ff.pre + 10'h001;
				end
			end
			default: begin
				nxt_st.state = BL_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{state: BL_IDLE, pre: 10'h000, steps: 8'h00};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// blank while transmitting, plus the tail; only in half duplex
	assign rx_blank = half_duplex && (tx_active || st_ff.state != BL_IDLE);

	// full duplex never blanks
	full_duplex_open_a: assert property (@(posedge pclk) disable iff (!presetn) // RL15
		!half_duplex |-> !rx_blank)
		else $error("receiver blanked in full duplex");

	// zero timeout releases right after transmit
	zero_tail_a: assert property (@(posedge pclk) disable iff (!presetn) // RL19
		half_duplex && timeout == 8'h00 && st_ff.state == BL_TRANSMIT && !tx_active
		|=> !rx_blank || tx_active)
		else $error("blanking outlived transmit at zero timeout");

endmodule

// ===== core/mode_config_regs.sv
// Function
// RL1 - three-bit parallel mode, printer at reset
// RL2 - ecp fifo threshold bits 6:3, reset 0111
// RL3 - pulsed type drives low pulse, then high-z
// RL4 - level type follows nack in epp modes
// RL5 - type bit ignored in printer, spp
// RL6 - ecp, test, fifo modes give level request
// RL7 - mux 00 normal, 01 split drives
// RL8 - mux 10 puts both drives on parallel
// RL9 - uart bit 0 enables midi, reset clear
// RL10 - uart bit 1 enables high speed
// RL11 - share bit merges both uart requests
// RL12 - software gives one uart no request
// RL13 - shared with two pins drives both
// RL14 - ir receive, transmit polarity bits
// RL15 - ir bit 2 selects half duplex
// RL16 - ir mode field standard, irda, ask
// RL17 - ir bit 6 picks alternate pins
// RL18 - turnaround register, 100 us steps, reset 03
// RL19 - zero blanks only during transmit
// RL20 - software writes zero to reserved bits
// RL21 - defaults only on hard reset
`include "mode_config_defs.svh"

module mode_config_regs
	import mode_config_pkg::*;
(
	input  wire logic        pclk,                      // apb clock, 10 MHz
	input  wire logic        presetn,                   // hard reset, active low
	input  wire logic        psel,                      // apb select
	input  wire logic        penable,                   // apb access phase
	input  wire logic        pwrite,                    // apb write
	input  wire logic [7:0]  paddr,                     // apb byte address
	input  wire logic [31:0] pwdata,                    // apb write data
	output logic      [31:0] prdata,                    // apb read data
	output logic             pready,                    // apb ready
	output logic             pslverr,                   // apb error
	input  wire logic        pp_ack_n,                  // printer acknowledge, active low
	input  wire logic        pp_event,                  // parallel port interrupt event
	output logic             pp_irq_o,                  // parallel request output value
	output logic             pp_irq_oe,                 // parallel request output enable
	output logic      [2:0]  pp_mode,                   // parallel port mode
	output logic      [3:0]  ecp_fifo_threshold,        // ecp fifo threshold
	output logic             floppy_over_parallel_select, // floppy on parallel pins
	output logic             split_drive_routing,       // drive 0 fdc, drive 1 parallel
	output logic             both_drives_on_parallel,   // both drives on parallel
	output logic      [1:0]  uart_midi_en,              // per uart midi enable
	output logic      [1:0]  uart_high_speed_en,        // per uart high speed
	input  wire logic [1:0]  uart_irq_in,               // per uart interrupt
	input  wire logic [1:0]  uart_irq_pin_assigned,     // uart has a request pin
	output logic      [1:0]  uart_irq_out,              // per uart request pin
	input  wire logic        ir_tx_data,                // infrared transmit bit
	input  wire logic        ir_tx_active,              // infrared transmitter busy
	output logic             second_uart_transmit_pin,  // ir transmit on uart 2 pin
	output logic             alternate_infrared_transmit_pin, // ir transmit alternate pin
	input  wire logic        second_uart_receive_pin,   // ir receive on uart 2 pin
	input  wire logic        alternate_infrared_receive_pin,  // ir receive alternate pin
	output logic             ir_rx_data,                // receive bit, active high
	output logic      [2:0]  ir_mode                    // infrared mode
);

	typedef struct packed {
		logic [7:0]  pp_mode_sel;
		logic [7:0]  pp_floppy;
		logic [7:0]  uart1_mode;
		logic [7:0]  uart2_mode;
		logic [7:0]  ir_opt;
		logic [7:0]  ir_time;
		logic [31:0] rdata;
	} regs_s;

	regs_s st_ff;
	regs_s nxt_st;

	logic wr_en;
	logic rd_en;
	logic addr_hit;
	logic pp_pulse;
	logic ir_blank;
	logic level_irq;
	logic pulsed_type;
	pp_mode_e mode_e;

	// checks below run on the bus clock, off in reset
	default clocking main_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	// address decode; unmapped answers with pslverr
	always_comb begin
		case (paddr)
			`ADDR_PARALLEL_MODE_SELECT,
			`ADDR_PARALLEL_FLOPPY_MUX,
			`ADDR_UART1_MODE_SELECT,
			`ADDR_UART2_MODE_SELECT,
			`ADDR_INFRARED_OPTIONS,
			`ADDR_INFRARED_TURNAROUND_TIME,
			`ADDR_STATUS: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	// zero wait states; error only on unmapped access
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_hit;
	assign prdata  = st_ff.rdata;

	// register writes, masked so reserved bits read zero
	always_comb begin
		nxt_st = st_ff;
		if (wr_en) begin
			case (paddr)
				`ADDR_PARALLEL_MODE_SELECT: begin
					// RL1 RL2 mode and threshold
					nxt_st.pp_mode_sel = pwdata[7:0] & `MASK_PARALLEL_MODE_SELECT;
				end
				`ADDR_PARALLEL_FLOPPY_MUX: begin
					nxt_st.pp_floppy = pwdata[7:0] & `MASK_PARALLEL_FLOPPY_MUX;
				end
				`ADDR_UART1_MODE_SELECT: begin
					nxt_st.uart1_mode = pwdata[7:0] & `MASK_UART1_MODE_SELECT;
				end
				`ADDR_UART2_MODE_SELECT: begin
					nxt_st.uart2_mode = pwdata[7:0] & `MASK_UART2_MODE_SELECT;
				end
				`ADDR_INFRARED_OPTIONS: begin
					nxt_st.ir_opt = pwdata[7:0] & `MASK_INFRARED_OPTIONS;
				end
				`ADDR_INFRARED_TURNAROUND_TIME: begin
					// RL18 full eight-bit timeout
					nxt_st.ir_time = pwdata[7:0];
				end
				default: begin
				end
			endcase
		end
		// read data captured in setup so it stands during access
		if (rd_en) begin
			case (paddr)
				`ADDR_PARALLEL_MODE_SELECT:     nxt_st.rdata = {24'h00_0000, st_ff.pp_mode_sel};
				`ADDR_PARALLEL_FLOPPY_MUX:      nxt_st.rdata = {24'h00_0000, st_ff.pp_floppy};
				`ADDR_UART1_MODE_SELECT:        nxt_st.rdata = {24'h00_0000, st_ff.uart1_mode};
				`ADDR_UART2_MODE_SELECT:        nxt_st.rdata = {24'h00_0000, st_ff.uart2_mode};
				`ADDR_INFRARED_OPTIONS:         nxt_st.rdata = {24'h00_0000, st_ff.ir_opt};
				`ADDR_INFRARED_TURNAROUND_TIME: nxt_st.rdata = {24'h00_0000, st_ff.ir_time};
				`ADDR_STATUS: nxt_st.rdata = {28'h000_0000, ir_blank, pp_pulse, uart_irq_out};
				default:                        nxt_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	// RL21 only the hard reset pin restores defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{pp_mode_sel: `RST_PARALLEL_MODE_SELECT,
			           pp_floppy:   `RST_PARALLEL_FLOPPY_MUX,
			           uart1_mode:  `RST_UART_MODE_SELECT,
			           uart2_mode:  `RST_UART_MODE_SELECT,
			           ir_opt:      `RST_INFRARED_OPTIONS,
			           ir_time:     `RST_INFRARED_TURNAROUND_TIME,
			           rdata:       32'h0000_0000};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// RL1 RL2 field outputs
	assign pp_mode            = st_ff.pp_mode_sel[2:0];
	assign ecp_fifo_threshold = st_ff.pp_mode_sel[6:3];
	assign mode_e             = pp_mode_e'(st_ff.pp_mode_sel[2:0]);

	// RL5 type bit has no effect in printer or spp
	assign pulsed_type = st_ff.pp_mode_sel[`BIT_PP_IRQ_TYPE]
	                     && mode_e != PP_PRINTER && mode_e != PP_SPP;

	// RL6 ecp, test and fifo-like modes use a level from the port
	// RL4 otherwise the request follows acknowledge
	always_comb begin
		case (mode_e)
			PP_ECP, PP_ECP_EPP19, PP_ECP_EPP17, PP_RESERVED: level_irq = pp_event;
			default: level_irq = !pp_ack_n;
		endcase
	end

	// RL3 pulsed request generator
	irq_pulse_gen u_pulse (
		.pclk         (pclk),
		.presetn      (presetn),
		.req          (level_irq),
		.pulse_active (pp_pulse)
	);

	// RL3 low pulse then high-z; level type drives the level
	assign pp_irq_o  = pulsed_type ? 1'b0 : level_irq;
	assign pp_irq_oe = pulsed_type ? pp_pulse : 1'b1;

	// RL7 RL8 floppy routing decode
	assign floppy_over_parallel_select = st_ff.pp_floppy[1:0] != FM_NORMAL;
	assign split_drive_routing         = st_ff.pp_floppy[1:0] == FM_SPLIT;
	assign both_drives_on_parallel     = st_ff.pp_floppy[1:0] == FM_BOTH;

	// RL9 RL10 per uart enables
	assign uart_midi_en       = {st_ff.uart2_mode[`BIT_UART_MIDI],
	                             st_ff.uart1_mode[`BIT_UART_MIDI]};
	assign uart_high_speed_en = {st_ff.uart2_mode[`BIT_UART_HIGH_SPEED],
	                             st_ff.uart1_mode[`BIT_UART_HIGH_SPEED]};

	// RL11 RL13 shared request drives every assigned pin; RL12 kept by software
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_uart_irq
			assign uart_irq_out[gi] = st_ff.uart1_mode[`BIT_UART_SHARE_IRQ]
			                          ? (|uart_irq_in) && uart_irq_pin_assigned[gi]
			                          : uart_irq_in[gi] && uart_irq_pin_assigned[gi];
		end
	endgenerate

	// RL16 infrared mode field
	assign ir_mode = st_ff.ir_opt[5:3];

	// RL15 RL19 receive blanking
	ir_blank_timer u_blank (
		.pclk        (pclk),
		.presetn     (presetn),
		.half_duplex (st_ff.ir_opt[`BIT_IR_HALF_DUPLEX]),
		.tx_active   (ir_tx_active),
		.timeout     (st_ff.ir_time),
		.rx_blank    (ir_blank)
	);

	// RL14 RL17 polarity and pin location; idle pin shows inactive level
	logic tx_line;
	logic rx_raw;
	assign tx_line = ir_tx_data ^ st_ff.ir_opt[`BIT_IR_TX_POL];
	assign second_uart_transmit_pin =
		st_ff.ir_opt[`BIT_IR_LOCATION] ? st_ff.ir_opt[`BIT_IR_TX_POL] : tx_line;
	assign alternate_infrared_transmit_pin =
		st_ff.ir_opt[`BIT_IR_LOCATION] ? tx_line : st_ff.ir_opt[`BIT_IR_TX_POL];
	assign rx_raw = st_ff.ir_opt[`BIT_IR_LOCATION] ? alternate_infrared_receive_pin
	                                               : second_uart_receive_pin;
	assign ir_rx_data = !ir_blank && (rx_raw ^ st_ff.ir_opt[`BIT_IR_RX_POL]);

	// write lands one cycle after the access edge
	write_takes_a: assert property ( // RL18
		wr_en && paddr == `ADDR_INFRARED_TURNAROUND_TIME |=> st_ff.ir_time == 8'($past(pwdata)))
		else $error("timeout write lost");

	// reserved bits stay zero
	reserved_zero_a: assert property ( // RL20
		st_ff.pp_floppy[7:2] == 6'h00 && st_ff.uart2_mode[7:2] == 6'h00
		&& st_ff.ir_opt[7] == 1'b0)
		else $error("reserved bit set");

	// printer and spp ignore the type bit
	type_ignored_a: assert property ( // RL5
		(mode_e == PP_PRINTER || mode_e == PP_SPP) |-> pp_irq_oe && pp_irq_o == !pp_ack_n)
		else $error("type bit acted in printer or spp");

	// shared request reaches both assigned pins
	share_both_a: assert property ( // RL13
		st_ff.uart1_mode[7] && (|uart_irq_in) && (&uart_irq_pin_assigned)
		|-> uart_irq_out == 2'b11)
		else $error("shared request missed a pin");

	// pulsed type never drives high
	pulse_low_a: assert property ( // RL3
		pulsed_type && pp_irq_oe |-> !pp_irq_o)
		else $error("pulsed request drove high");

	// routing flags are exclusive
	route_excl_a: assert property ( // RL8
		!(split_drive_routing && both_drives_on_parallel))
		else $error("both routings selected");

	// blanked receive reads idle
	rx_blank_a: assert property ( // RL19
		ir_tx_active && st_ff.ir_opt[2] |-> !ir_rx_data)
		else $error("receive open during half duplex transmit");

	// mode register moves only on its own write
	pp_hold_a: assert property ( // RL21
		!(wr_en && paddr == `ADDR_PARALLEL_MODE_SELECT)
		|=> $stable(st_ff.pp_mode_sel))
		else $error("mode register changed");

	// share bit moves only on its own write
	uart_hold_a: assert property ( // RL21
		!(wr_en && paddr == `ADDR_UART1_MODE_SELECT)
		|=> $stable(st_ff.uart1_mode))
		else $error("uart1 register changed");

	// level styles always drive the pin
	level_drive_a: assert property ( // RL6
		!pulsed_type
		|-> pp_irq_oe)
		else $error("level request not driven");

	// ecp level passes the port event
	ecp_level_a: assert property ( // RL6
		mode_e == PP_ECP && !pulsed_type
		|-> pp_irq_o == pp_event)
		else $error("ecp request lost event");

	// epp level follows acknowledge
	epp_follow_a: assert property ( // RL4
		(mode_e == PP_EPP19 || mode_e == PP_EPP17) && !pulsed_type
		|-> pp_irq_o == !pp_ack_n)
		else $error("epp request ignored ack");

	// without sharing each uart keeps its own pin
	uart_apart_a: assert property ( // RL11
		!st_ff.uart1_mode[`BIT_UART_SHARE_IRQ]
		|-> uart_irq_out == (uart_irq_in & uart_irq_pin_assigned))
		else $error("uart requests mixed");

	// no request, no pin, shared or not
	uart_quiet_a: assert property ( // RL11
		!(|uart_irq_in)
		|-> uart_irq_out == 2'b00)
		else $error("uart pin without request");

	// normal routing keeps the floppy off the port
	floppy_off_a: assert property ( // RL7
		st_ff.pp_floppy[1:0] == 2'b00
		|-> !floppy_over_parallel_select)
		else $error("floppy routed in normal mode");

	// both drives imply the parallel select
	mux_both_a: assert property ( // RL8
		st_ff.pp_floppy[1:0] == 2'b10
		|-> both_drives_on_parallel && floppy_over_parallel_select)
		else $error("both drive routing missing");

	// unused transmit pin rests inactive
	tx_idle_a: assert property ( // RL17
		!st_ff.ir_opt[`BIT_IR_LOCATION]
		|-> alternate_infrared_transmit_pin == st_ff.ir_opt[`BIT_IR_TX_POL])
		else $error("alternate transmit pin not idle");

	// open receiver honours the polarity bit
	rx_pol_a: assert property ( // RL14
		!ir_blank && !st_ff.ir_opt[`BIT_IR_LOCATION]
		|-> ir_rx_data == (second_uart_receive_pin ^ st_ff.ir_opt[`BIT_IR_RX_POL]))
		else $error("receive polarity wrong");

endmodule

// ===== test/pp_uart_ir_mode_config_tb_top.sv
`include "mode_config_defs.svh"

module pp_uart_ir_mode_config_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import mode_config_pkg::*;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pp_ack_n, pp_event, pp_irq_o, pp_irq_oe;
	logic [2:0]  pp_mode, ir_mode;
	logic [3:0]  ecp_fifo_threshold;
	logic        floppy_over_parallel_select, split_drive_routing, both_drives_on_parallel;
	logic [1:0]  uart_midi_en, uart_high_speed_en, uart_irq_in, uart_irq_pin_assigned;
	logic [1:0]  uart_irq_out;
	logic        ir_tx_data, ir_tx_active, second_uart_transmit_pin;
	logic        alternate_infrared_transmit_pin, second_uart_receive_pin;
	logic        alternate_infrared_receive_pin, ir_rx_data;
	int          err_total = 0;
	int          n_tests = 0;
	logic [31:0] seed = 32'h0000_0027;
	logic [7:0]  sh [6];
	logic [7:0]  adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
	logic [7:0]  rst [6] = '{8'h3C, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03};
	logic [7:0]  msk [6] = '{8'hFF, 8'h03, 8'h83, 8'h03, 8'h7F, 8'hFF};

	mode_config_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pp_ack_n, .pp_event, .pp_irq_o, .pp_irq_oe, .pp_mode,
		.ecp_fifo_threshold, .floppy_over_parallel_select, .split_drive_routing,
		.both_drives_on_parallel, .uart_midi_en, .uart_high_speed_en, .uart_irq_in,
		.uart_irq_pin_assigned, .uart_irq_out, .ir_tx_data, .ir_tx_active,
		.second_uart_transmit_pin, .alternate_infrared_transmit_pin,
		.second_uart_receive_pin, .alternate_infrared_receive_pin, .ir_rx_data, .ir_mode);

	// free running 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// xorshift source, fixed start so every run repeats
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// expected request pins: shared mode fans the merged request to every wired pin
	function automatic logic [1:0] exp_uart(logic [1:0] req, logic [1:0] asg, logic shr);
		return shr ? (asg & {2{|req}}) : (req & asg);
	endfunction

	// expected {uart2 tx pin, alternate tx pin, receive bit}; unused pin idles inactive
	function automatic logic [2:0] exp_ir(logic [7:0] o, logic txd, logic r2, logic ra);
		logic t;
		t = txd ^ o[1];
		return {o[6] ? o[1] : t, o[6] ? t : o[1], (o[6] ? ra : r2) ^ o[0]};
	endfunction

	task automatic finish_test();
		if (err_total == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one apb transfer; wait on pready is bounded so a stuck slave ends the run
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr_reg(input int i, input logic [7:0] v);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, adr[i], (rnd() & 32'hFFFF_FF00) | 32'(v), rd, e);
		sh[i] = v & msk[i];
		check("write error", 32'(e), 32'h0000_0000);
	endtask

	// field outputs follow the shadow copy one edge after the write lands
	task automatic check_fields();
		logic [1:0] fm;
		@(posedge pclk);
		fm = sh[1][1:0];
		check("pp mode", 32'(pp_mode), 32'(sh[0][2:0]));
		check("fifo threshold", 32'(ecp_fifo_threshold), 32'(sh[0][6:3]));
		check("split", 32'(split_drive_routing), 32'(fm == 2'b01));
		check("both", 32'(both_drives_on_parallel), 32'(fm == 2'b10));
		if (fm != 2'b11) check("mux sel", 32'(floppy_over_parallel_select), 32'(fm != 0));
		check("midi", 32'(uart_midi_en), 32'({sh[3][0], sh[2][0]}));
		check("high speed", 32'(uart_high_speed_en), 32'({sh[3][1], sh[2][1]}));
		check("ir mode", 32'(ir_mode), 32'(sh[4][5:3]));
	endtask

	initial begin
		logic [31:0] rd;
		logic        e;
		logic [2:0]  ex;
		int          cnt;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{pp_ack_n, pp_event, uart_irq_in, uart_irq_pin_assigned} = 6'b10_0000;
		{ir_tx_data, ir_tx_active, second_uart_receive_pin, alternate_infrared_receive_pin} = '0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and masked random write/read of every writable register
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, adr[i], 32'h0000_0000, rd, e);
			check("reset value", rd, 32'(rst[i]));
			sh[i] = rst[i];
		end
		check_fields();
		for (int k = 0; k < 8; k++) begin
			for (int i = 0; i < 6; i++) begin
				wr_reg(i, 8'(rnd()));
				apb(1'b0, adr[i], 32'h0000_0000, rd, e);
				check("read back", rd, 32'(sh[i]));
			end
			check_fields();
		end
		// every parallel mode and infrared mode code, floppy routings normal, split and both
		for (int m = 0; m < 8; m++) begin
			wr_reg(0, {1'b0, 4'(m + 3), 3'(m)});
			wr_reg(1, 8'(m % 3));
			wr_reg(4, {2'b00, 3'(m % 4), 3'b000});
			check_fields();
		end
		// unmapped places answer with an error and read zero
		apb(1'b1, 8'h1C, 32'hFFFF_FFFF, rd, e);
		check("unmapped write err", 32'(e), 32'h0000_0001);
		apb(1'b0, 8'h40, 32'h0000_0000, rd, e);
		check("unmapped read err", 32'(e), 32'h0000_0001);
		check("unmapped read data", rd, 32'h0000_0000);
		// interrupt sharing, with the share bit both ways
		for (int k = 0; k < 32; k++) begin
			if (k % 16 == 0) wr_reg(2, {k[4], 7'h00});
			uart_irq_in <= 2'(rnd());
			uart_irq_pin_assigned <= 2'(rnd());
			@(posedge pclk);
			@(posedge pclk);
			check("uart irq", 32'(uart_irq_out),
				32'(exp_uart(uart_irq_in, uart_irq_pin_assigned, sh[2][7])));
		end
		// software shares, then keeps one uart without a pin
		wr_reg(2, 8'h80);
		uart_irq_pin_assigned <= 2'b01;
		uart_irq_in <= 2'b10;
		repeat (2) @(posedge pclk);
		check("shared irq", 32'(uart_irq_out), 32'h0000_0001);
		apb(1'b0, 8'h18, 32'h0000_0000, rd, e);
		check("status irq", 32'(rd[1:0]), 32'(exp_uart(2'b10, 2'b01, 1'b1)));
		// full duplex infrared routing and polarity
		for (int k = 0; k < 24; k++) begin
			if (k % 3 == 0) wr_reg(4, 8'(rnd()) & 8'h7B);
			{ir_tx_data, second_uart_receive_pin, alternate_infrared_receive_pin} <= 3'(rnd());
			ir_tx_active <= k[0];
			@(posedge pclk);
			@(posedge pclk);
			ex = exp_ir(sh[4], ir_tx_data, second_uart_receive_pin,
				alternate_infrared_receive_pin);
			check("ir pins", 32'({second_uart_transmit_pin, alternate_infrared_transmit_pin,
				ir_rx_data}), 32'(ex));
		end
		// half duplex blanking with one 100 us step, then with none
		wr_reg(4, 8'h04);
		second_uart_receive_pin <= 1'b1;
		for (int t = 1; t >= 0; t--) begin
			wr_reg(5, 8'(t));
			ir_tx_active <= 1'b1;
			repeat (5) @(posedge pclk);
			check("blank in tx", 32'(ir_rx_data), 32'h0000_0000);
			ir_tx_active <= 1'b0;
			repeat (t * 995 + 1) @(posedge pclk);
			if (t == 1) check("blank tail", 32'(ir_rx_data), 32'h0000_0000);
			repeat (t * 10 + 5) @(posedge pclk);
			check("blank over", 32'(ir_rx_data), 32'h0000_0001);
		end
		// level request in ecp mode follows the port event
		wr_reg(0, 8'h3A);
		for (int k = 0; k < 8; k++) begin
			pp_event <= k[0];
			@(posedge pclk);
			@(posedge pclk);
			check("ecp level", 32'({pp_irq_oe, pp_irq_o}), 32'({1'b1, pp_event}));
		end
		// level type in epp tracks acknowledge
		wr_reg(0, 8'h39);
		for (int k = 0; k < 6; k++) begin
			pp_ack_n <= k[0];
			@(posedge pclk);
			@(posedge pclk);
			check("epp level", 32'({pp_irq_oe, pp_irq_o}), 32'({1'b1, ~pp_ack_n}));
		end
		// pulsed type: one low pulse per acknowledge, ignored in printer mode
		for (int m = 0; m < 2; m++) begin
			pp_ack_n <= 1'b1;
			wr_reg(0, m ? 8'hB9 : 8'hBC);
			repeat (10) @(posedge pclk);
			cnt = 0;
			for (int i = 0; i < 50; i++) begin
				@(posedge pclk);
				if (i == 2) pp_ack_n <= 1'b0;
				if (i == 12) pp_ack_n <= 1'b1;
				if (m == 0) check("printer drives", 32'(pp_irq_oe), 32'h0000_0001);
				cnt += int'(pp_irq_oe === 1'b1 && pp_irq_o === 1'b0);
			end
			if (m == 1) check("pulse length", cnt, `IRQ_PULSE_CYCLES);
			if (m == 1) check("pulse release", 32'(pp_irq_oe), 32'h0000_0000);
		end
		finish_test();
	end
endmodule
